// *** shared/spsm_pkg.sv ***
// Purpose: Shared constants and types of the shift-mode serial port
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   Machine-cycle positions run S1P1 = 0 up to S6P2 = 11
`default_nettype none

package spsm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned REG_AW        = 8;
  localparam logic [7:0]  OFS_SER_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_SER_BUF   = 8'h04;
  localparam logic [7:0]  OFS_CLK_CFG   = 8'h08;

  // serial_control and clock-config field positions
  localparam int unsigned SC_MODE_HI    = 7;
  localparam int unsigned SC_MODE_LO    = 6;
  localparam int unsigned SC_ADDR_FILT  = 5;
  localparam int unsigned SC_RX_EN      = 4;
  localparam int unsigned SC_TX_NINTH   = 3;
  localparam int unsigned SC_RX_NINTH   = 2;
  localparam int unsigned SC_TX_DONE    = 1;
  localparam int unsigned SC_RX_DONE    = 0;
  localparam int unsigned CFG_SIX_CLK   = 0;

  localparam logic [7:0]  SC_RESET      = 8'h00;
  localparam logic [7:0]  SER_BUF_RESET = 8'h00;
  localparam logic        SIX_CLK_RESET = 1'b1;
  localparam logic [1:0]  MODE_SHIFT    = 2'h0;

  // ----------------------------------------------------------------
  // Machine-cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned MC_POS_W      = 4;
  localparam int unsigned MC_TICKS      = 12;
  localparam logic [3:0]  MC_POS_LAST   = 4'hB;
  localparam logic [2:0]  MC_STATE_LAST = 3'h5;
  localparam int unsigned T_S1P1        = 0;
  localparam int unsigned T_S3P1        = 4;
  localparam int unsigned T_S5P2        = 9;
  localparam int unsigned T_S6P1        = 10;
  localparam int unsigned T_S6P2        = 11;

  // ----------------------------------------------------------------
  // Shift patterns and AHB-Lite transfer codes
  // ----------------------------------------------------------------
  localparam logic        TX_MARKER     = 1'b1;
  localparam logic [8:0]  TX_LAST_PAT   = 9'h001;
  localparam logic [7:0]  RX_LOAD_PAT   = 8'hFE;
  localparam logic [1:0]  HTRANS_NSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_REQ  = 5'b00010,
    TX_WAIT = 5'b00100,
    TX_GAP  = 5'b01000,
    TX_SEND = 5'b10000
  } spsm_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_ARM  = 5'b00010,
    RX_LOAD = 5'b00100,
    RX_RUN  = 5'b01000,
    RX_LAST = 5'b10000
  } spsm_rx_state_t;

endpackage

`default_nettype wire

// *** src/spsm_seq.sv ***
// Purpose: Machine-cycle sequencer, six states of two phases each
// Assumes: clk is the oscillator
// Notes:   In 6-clock timing both phases of a state strobe together
`timescale 1ns/1ps
`default_nettype none

module spsm_seq
  import spsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        six_clk,
  output logic [11:0]      tick
);

  logic [3:0] pos_reg;
  logic [3:0] pos_next;

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  always_comb begin
    if (six_clk) begin
      if (pos_reg[3:1] == MC_STATE_LAST) begin
        pos_next = 4'h0;
      end else begin
        pos_next = {pos_reg[3:1] + 3'h1, 1'b0};
      end
    end else if (pos_reg == MC_POS_LAST) begin
      pos_next = 4'h0;
    end else begin
      pos_next = pos_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 4'h0;
    end else begin
      pos_reg <= pos_next; // [R20]
    end
  end

  // Even position is P1; six-clock mode fires its P2 in the same clock
  always_comb begin
    tick = 12'h000;
    tick[pos_reg] = 1'b1;
    if (six_clk) begin
      tick[{pos_reg[3:1], 1'b1}] = 1'b1; // [R05]
    end
  end

endmodule

`default_nettype wire

// *** src/spsm_ahb.sv ***
// Purpose: AHB-Lite slave front end, zero wait states, OKAY only
// Assumes: single word transfers
// Notes:   Write strobe is issued in the data phase with hwdata
`timescale 1ns/1ps
`default_nettype none

module spsm_ahb
  import spsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] rd_data,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data
);

  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic       take;

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite && (hsize == HSIZE_WORD);
      if (take) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // Read data captured at the address phase, so it stands in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign wr_en   = wr_pend_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = hwdata[7:0];

endmodule

`default_nettype wire

// *** src/spsm_top.sv ***
// Purpose: Serial port, synchronous shift-register mode, AHB-Lite registers
// Assumes: clk is the oscillator; pins synchronous to clk
// Notes:   Only mode 0 moves data; other modes keep their fields only
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: Received ninth bit unused in shift mode
// R02: Transmit-done set after eighth bit, software clears
// R03: Receive-done set after eighth bit, software clears
// R04: Eight bits LSB first, clock on pin
// R05: Bit rate oscillator over twelve or six
// R06: Buffer write starts transmit, loads marker one
// R07: One full machine cycle before transmit-active
// R08: Transmit-active routes shift bit and clock out
// R09: Shift clock low S3-S5, high S6-S2
// R10: Transmit shifts right at S6P2
// R11: Zeros in; marker alone ends transmission
// R12: Transmit ends at S1P1, tenth cycle
// R13: Receive starts on enable set, done clear
// R14: Load 11111110 at S6P2, active next phase
// R15: Receive drives clock, toggles S3P1, S6P1
// R16: Receive shifts at S6P2 while active
// R17: Shift left, bit sampled at S5P2
// R18: Zero at top: last shift, load, flag
// R19: Transmit ninth bit kept for nine-bit modes
// R20: Six-state two-phase machine-cycle sequencer
module spsm_top
  import spsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        port3_bit0_in,
  output logic             port3_bit0_out,
  output logic             port3_bit0_oe,
  output logic             port3_bit1_out,
  output logic             port3_bit1_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [11:0]    tick;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [7:0]     wr_data;
  logic [31:0]    rd_data;

  logic [1:0]     mode_reg;
  logic           addr_filt_reg;
  logic           rx_en_reg;
  logic           tx_ninth_reg;
  logic           rx_ninth_reg;
  logic           tx_done_reg;
  logic           rx_done_reg;
  logic           six_clk_reg;
  logic [7:0]     tx_data_reg;
  logic [8:0]     tx_shift_reg;
  logic [7:0]     rx_shift_reg;
  logic [7:0]     rx_buf_reg;
  logic           sample_reg;
  logic           sclk_reg;

  spsm_tx_state_t tx_state_reg;
  spsm_tx_state_t tx_state_next;
  spsm_rx_state_t rx_state_reg;
  spsm_rx_state_t rx_state_next;

  logic           wr_ctrl;
  logic           wr_buf;
  logic           wr_cfg;
  logic           shift_mode;
  logic           tx_done_set;
  logic           rx_done_set;
  logic           rx_start_ok;
  logic           tx_active;
  logic           rx_active;
  logic [7:0]     ctrl_view;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  spsm_seq u_seq (
    .clk     (clk),
    .rst_n   (rst_n),
    .six_clk (six_clk_reg),
    .tick    (tick)
  );

  spsm_ahb u_ahb (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .rd_data   (rd_data),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_ctrl    = wr_en && (wr_addr == OFS_SER_CTRL);
  assign wr_buf     = wr_en && (wr_addr == OFS_SER_BUF);
  assign wr_cfg     = wr_en && (wr_addr == OFS_CLK_CFG);
  assign shift_mode = (mode_reg == MODE_SHIFT);

  assign ctrl_view = {mode_reg, addr_filt_reg, rx_en_reg,
                      tx_ninth_reg, rx_ninth_reg, tx_done_reg, rx_done_reg};

  always_comb begin
    if (haddr[7:0] == OFS_SER_CTRL) begin
      rd_data = {24'h00_0000, ctrl_view};
    end else if (haddr[7:0] == OFS_SER_BUF) begin
      rd_data = {24'h00_0000, rx_buf_reg};
    end else if (haddr[7:0] == OFS_CLK_CFG) begin
      rd_data = {31'h0000_0000, six_clk_reg};
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= SC_RESET[SC_MODE_HI:SC_MODE_LO];
      addr_filt_reg <= SC_RESET[SC_ADDR_FILT];
      rx_en_reg     <= SC_RESET[SC_RX_EN];
      tx_ninth_reg  <= SC_RESET[SC_TX_NINTH];
    end else if (wr_ctrl) begin
      mode_reg      <= wr_data[SC_MODE_HI:SC_MODE_LO];
      addr_filt_reg <= wr_data[SC_ADDR_FILT];
      rx_en_reg     <= wr_data[SC_RX_EN];
      tx_ninth_reg  <= wr_data[SC_TX_NINTH]; // [R19]
    end
  end

  // Shift mode never writes it; only software does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ninth_reg <= SC_RESET[SC_RX_NINTH];
    end else if (wr_ctrl) begin
      rx_ninth_reg <= wr_data[SC_RX_NINTH]; // [R01]
    end
  end

  // Hardware set wins over a clearing write in the same clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_done_reg <= SC_RESET[SC_TX_DONE];
    end else if (tx_done_set) begin
      tx_done_reg <= 1'b1; // [R02]
    end else if (wr_ctrl) begin
      tx_done_reg <= wr_data[SC_TX_DONE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_reg <= SC_RESET[SC_RX_DONE];
    end else if (rx_done_set) begin
      rx_done_reg <= 1'b1; // [R03]
    end else if (wr_ctrl) begin
      rx_done_reg <= wr_data[SC_RX_DONE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      six_clk_reg <= SIX_CLK_RESET;
    end else if (wr_cfg) begin
      six_clk_reg <= wr_data[CFG_SIX_CLK]; // [R05]
    end
  end

  // ----------------------------------------------------------------
  // Transmit control
  // ----------------------------------------------------------------
  assign tx_active   = (tx_state_reg == TX_SEND);
  assign tx_done_set = tx_active && tick[T_S1P1] && (tx_shift_reg == TX_LAST_PAT);

  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      TX_IDLE: begin
        if (wr_buf && shift_mode && (rx_state_reg == RX_IDLE)) begin
          tx_state_next = TX_REQ; // [R06]
        end
      end
      TX_REQ: begin
        if (tick[T_S6P2]) begin
          tx_state_next = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tick[T_S1P1]) begin
          tx_state_next = TX_GAP; // [R07]
        end
      end
      TX_GAP: begin
        if (tick[T_S1P1]) begin
          tx_state_next = TX_SEND; // [R07]
        end
      end
      TX_SEND: begin
        if (tx_done_set) begin
          tx_state_next = TX_IDLE; // [R12]
        end
      end
      default: begin
        tx_state_next = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
    end else begin
      tx_state_reg <= tx_state_next;
    end
  end

  // Data held from the write until the S6P2 load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_reg <= SER_BUF_RESET;
    end else if (wr_buf && (tx_state_reg == TX_IDLE)) begin
      tx_data_reg <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg <= 9'h000;
    end else if ((tx_state_reg == TX_REQ) && tick[T_S6P2]) begin
      tx_shift_reg <= {TX_MARKER, tx_data_reg}; // [R06]
    end else if (tx_active && tick[T_S6P2]) begin
      tx_shift_reg <= {1'b0, tx_shift_reg[8:1]}; // [R10] [R11] [R04]
    end
  end

  // ----------------------------------------------------------------
  // Receive control
  // ----------------------------------------------------------------
  // Active from the phase right after the pattern load
  assign rx_active   = (rx_state_reg == RX_LOAD) || (rx_state_reg == RX_RUN)
                       || (rx_state_reg == RX_LAST); // [R14]
  assign rx_start_ok = rx_en_reg && !rx_done_reg && shift_mode
                       && (tx_state_reg == TX_IDLE) && !wr_buf;
  assign rx_done_set = (rx_state_reg == RX_LAST) && tick[T_S1P1];

  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      RX_IDLE: begin
        if (rx_start_ok && tick[T_S1P1]) begin
          rx_state_next = RX_ARM; // [R13]
        end
      end
      RX_ARM: begin
        if (tick[T_S6P2]) begin
          rx_state_next = RX_LOAD; // [R14]
        end
      end
      RX_LOAD: begin
        if (tick[T_S1P1]) begin
          rx_state_next = RX_RUN; // [R14]
        end
      end
      RX_RUN: begin
        if (tick[T_S6P2] && !rx_shift_reg[7]) begin
          rx_state_next = RX_LAST; // [R18]
        end
      end
      RX_LAST: begin
        if (tick[T_S1P1]) begin
          rx_state_next = RX_IDLE; // [R18]
        end
      end
      default: begin
        rx_state_next = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
    end else begin
      rx_state_reg <= rx_state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= 1'b0;
    end else if (tick[T_S5P2]) begin
      sample_reg <= port3_bit0_in; // [R17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg <= 8'h00;
    end else if ((rx_state_reg == RX_ARM) && tick[T_S6P2]) begin
      rx_shift_reg <= RX_LOAD_PAT; // [R14]
    end else if ((rx_state_reg == RX_RUN) && tick[T_S6P2]) begin
      rx_shift_reg <= {rx_shift_reg[6:0], sample_reg}; // [R16] [R17] [R04]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_reg <= SER_BUF_RESET;
    end else if (rx_done_set) begin
      // First bit in ends at the top; buffer holds it in bit 0
      rx_buf_reg <= {rx_shift_reg[0], rx_shift_reg[1], rx_shift_reg[2],
                     rx_shift_reg[3], rx_shift_reg[4], rx_shift_reg[5],
                     rx_shift_reg[6], rx_shift_reg[7]}; // [R18] [R04]
    end
  end

  // ----------------------------------------------------------------
  // Shift clock and pins
  // ----------------------------------------------------------------
  // Same waveform for both directions: low S3..S5, high S6..S2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= 1'b1;
    end else if (tick[T_S3P1]) begin
      sclk_reg <= 1'b0; // [R09] [R15]
    end else if (tick[T_S6P1]) begin
      sclk_reg <= 1'b1; // [R09] [R15]
    end
  end

  // Pins lag the internal state by one oscillator clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_bit0_out <= 1'b1;
      port3_bit0_oe  <= 1'b0;
      port3_bit1_out <= 1'b1;
      port3_bit1_oe  <= 1'b0;
    end else begin
      port3_bit0_out <= tx_active ? tx_shift_reg[0] : 1'b1; // [R08]
      port3_bit0_oe  <= tx_active;                          // [R08] [R04]
      port3_bit1_out <= sclk_reg;                           // [R08] [R15]
      port3_bit1_oe  <= tx_active || rx_active;             // [R08] [R15]
    end
  end

endmodule

`default_nettype wire

// *** verif/spsm_top_assertions.sv ***
// Purpose: Pin-level checks of the shift-mode serial port
// Assumes: Pins are registered and lag internal state by one clock
// Notes:   Bound into spsm_top; bind follows the module
`timescale 1ns/1ps
`default_nettype none

module spsm_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port3_bit0_out,
  input wire logic port3_bit0_oe,
  input wire logic port3_bit1_out,
  input wire logic port3_bit1_oe
);
  logic [7:0] n_cyc;
  logic [3:0] n_fall;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Frame counters, cleared whenever the data pin is released
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      n_cyc <= 8'h00;
    else
      n_cyc <= port3_bit0_oe ? n_cyc + 8'h01 : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      n_fall <= 4'h0;
    else
      n_fall <= port3_bit0_oe ? n_fall + {3'h0, $fell(port3_bit1_out)} : 4'h0;
  end

  sequence s_lo;
    !port3_bit1_out [*2];
  endsequence
  sequence s_hi;
    port3_bit1_out [*2];
  endsequence

  property p_route;
    port3_bit0_oe |-> port3_bit1_oe;
  endproperty
  property p_idle;
    !port3_bit0_oe |-> port3_bit0_out;
  endproperty
  property p_low;
    $fell(port3_bit1_out) |=> s_lo;
  endproperty
  property p_high;
    $rose(port3_bit1_out) |=> s_hi;
  endproperty
  property p_rate;
    $fell(port3_bit1_out) |=> (!$fell(port3_bit1_out)) [*5];
  endproperty
  property p_hold;
    port3_bit0_oe && $past(port3_bit0_oe) && $changed(port3_bit0_out) |-> port3_bit1_out;
  endproperty
  property p_bits;
    $fell(port3_bit0_oe) |-> n_fall == 4'h8;
  endproperty
  property p_len;
    $fell(port3_bit0_oe) |-> n_cyc == 8'h30 || n_cyc == 8'h60;
  endproperty
  property p_end;
    $fell(port3_bit0_oe) |-> !port3_bit1_oe;
  endproperty

  a_route: assert property (p_route)
    else $error("data pin driven without clock pin");
  a_idle: assert property (p_idle)
    else $error("data pin low while released");
  a_low: assert property (p_low)
    else $error("shift clock low phase too short");
  a_high: assert property (p_high)
    else $error("shift clock high phase too short");
  a_rate: assert property (p_rate)
    else $error("shift clock period below six clocks");
  a_hold: assert property (p_hold)
    else $error("data bit changed while shift clock low");
  a_bits: assert property (p_bits)
    else $error("transmit frame without eight clock pulses");
  a_len: assert property (p_len)
    else $error("transmit frame not eight machine cycles");
  a_end: assert property (p_end)
    else $error("clock pin still driven after transmit");
endmodule

bind spsm_top spsm_top_chk u_chk (
  .clk            (clk),
  .rst_n          (rst_n),
  .port3_bit0_out (port3_bit0_out),
  .port3_bit0_oe  (port3_bit0_oe),
  .port3_bit1_out (port3_bit1_out),
  .port3_bit1_oe  (port3_bit1_oe)
);

`default_nettype wire

// *** verif/spsm_peer.sv ***
// Purpose: External shift register on the far side of the serial pins
// Assumes: Wire levels are resolved by the bench
// Notes:   Captures on falling shift clock, mid bit, to avoid edge races
`timescale 1ns/1ps
`default_nettype none

module spsm_peer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       sdat,
  input  wire logic       dev_oe,
  input  wire logic       dclk_oe,
  input  wire logic [7:0] rx_byte,
  output logic            drv,
  output logic            drv_en,
  output logic [7:0]      got,
  output logic            got_v
);
  logic       sck_q;
  logic       oe_q;
  logic [3:0] n;
  logic [2:0] k;
  logic [7:0] sh;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q  <= 1'b1;
      oe_q   <= 1'b0;
      n      <= 4'h0;
      k      <= 3'h0;
      sh     <= 8'h00;
      got    <= 8'h00;
      got_v  <= 1'b0;
      drv    <= 1'b1;
      drv_en <= 1'b0;
    end else begin
      sck_q <= sck;
      oe_q  <= dclk_oe;
      got_v <= 1'b0;
      if (dev_oe && sck_q && !sck) begin
        sh <= {sdat, sh[7:1]};
        n  <= n + 4'h1;
      end
      if (n == 4'h8) begin
        got   <= sh;
        got_v <= 1'b1;
        n     <= 4'h0;
      end
      // Clock drive without data drive marks a receive frame
      if (dclk_oe && !oe_q && !dev_oe) begin
        drv_en <= 1'b1;
        drv    <= rx_byte[0];
        k      <= 3'h1;
      end else if (drv_en && !sck_q && sck) begin
        drv <= rx_byte[k];
        k   <= k + 3'h1;
      end
      if (!dclk_oe && oe_q)
        drv_en <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench of the shift-mode serial port
// Assumes: Zero-wait AHB-Lite slave; pins resolved here
// Notes:   Both clock timings are run; mode 3 only holds fields
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import spsm_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hready, hreadyout, hresp;
  logic [31:0] hrdata, rd_v;
  logic        p0_out, p0_oe, p1_out, p1_oe;
  logic        sdat, sck, last_q, drv, drv_en, got_v;
  logic [7:0]  got, b, rxb = 8'h00;
  integer      err_count = 0, n_tests = 0, seed = 32'h0eb47981, m;
  logic [31:0] q_rd[$];
  logic [7:0]  q_tx[$];
  event        rd_ev;

  always #12.5 clk = ~clk;
  assign hready = hreadyout;
  // Released data line shows the inverse of its last level; clock pulled up
  assign sdat = p0_oe ? p0_out : (drv_en ? drv : ~last_q);
  assign sck  = p1_oe ? p1_out : 1'b1;
  always @(posedge clk) last_q <= sdat;

  spsm_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port3_bit0_in(sdat),
    .port3_bit0_out(p0_out), .port3_bit0_oe(p0_oe), .port3_bit1_out(p1_out),
    .port3_bit1_oe(p1_oe));
  spsm_peer u_peer (.clk(clk), .rst_n(rst_n), .sck(sck), .sdat(sdat), .dev_oe(p0_oe),
    .dclk_oe(p1_oe), .rx_byte(rxb), .drv(drv), .drv_en(drv_en), .got(got), .got_v(got_v));

  // ----------------------------------------------------------------
  // Bus cycles, comparison and closing
  // ----------------------------------------------------------------
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task ahb(logic is_wr, logic [7:0] a, logic [31:0] d, logic [2:0] sz);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= is_wr;
    hsize  <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask

  task wr(logic [7:0] a, logic [31:0] d);
    ahb(1'b1, a, d, HSIZE_WORD);
  endtask

  task rd(logic [7:0] a, logic [31:0] exp);
    q_rd.push_back(exp);
    ahb(1'b0, a, 32'h0, HSIZE_WORD);
    -> rd_ev;
  endtask

  task wait_bit(int unsigned bi);
    int i;
    i = 0;
    do begin
      ahb(1'b0, OFS_SER_CTRL, 32'h0, HSIZE_WORD);
      i++;
    end while (rd_v[bi] !== 1'b1 && i < 400);
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always begin
    @(rd_ev);
    chk("hrdata", rd_v, q_rd.pop_front());
    chk("bus resp", {30'h0, hreadyout, hresp}, 32'h2);
  end

  always @(posedge clk) begin
    if (got_v === 1'b1)
      chk("tx byte", {24'h0, got}, q_tx.size() ? {24'h0, q_tx.pop_front()} : '1);
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_SER_CTRL, {24'h0, SC_RESET});
    rd(OFS_SER_BUF, {24'h0, SER_BUF_RESET});
    rd(OFS_CLK_CFG, {31'h0, SIX_CLK_RESET});
    rd(8'h0C, 32'h0);
    ahb(1'b1, OFS_CLK_CFG, 32'h0, 3'h0);
    rd(OFS_CLK_CFG, {31'h0, SIX_CLK_RESET});
    for (m = 0; m < 2; m++) begin
      wr(OFS_CLK_CFG, {31'h0, m == 0});
      b = 8'($random(seed));
      q_tx.push_back(b);
      wr(OFS_SER_BUF, {24'h0, b});
      repeat (30) @(posedge clk);
      wr(OFS_SER_BUF, {24'h0, ~b});
      wait_bit(SC_TX_DONE);
      rd(OFS_SER_CTRL, 32'h02);
      repeat (40) @(posedge clk);
      rd(OFS_SER_CTRL, 32'h02);
      wr(OFS_SER_CTRL, 32'h0);
      rd(OFS_SER_CTRL, 32'h0);
      rxb <= 8'($random(seed));
      wr(OFS_SER_CTRL, 32'h10);
      wait_bit(SC_RX_DONE);
      rd(OFS_SER_BUF, {24'h0, rxb});
      rd(OFS_SER_CTRL, 32'h11);
      repeat (100) @(negedge clk);
      chk("no restart", {31'h0, p1_oe}, 32'h0);
      wr(OFS_SER_CTRL, 32'h0);
    end
    wr(OFS_SER_CTRL, 32'hFC);
    rd(OFS_SER_CTRL, 32'hFC);
    wr(OFS_SER_BUF, 32'h5A);
    repeat (300) @(negedge clk);
    chk("pin oe", {30'h0, p1_oe, p0_oe}, 32'h0);
    rd(OFS_SER_CTRL, 32'hFC);
    wrap_up;
  end
endmodule

`default_nettype wire
